// [shared/asr_pkg.sv]
// Package of register map, field layouts and state types for the receiver.
package asr_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_BAUD  = 8'h04;
	localparam logic [7:0] OFS_RXBUF = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [7:0] OFS_FLAG  = 8'h10;
	localparam logic [7:0] OFS_PWR   = 8'h14;

	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] MODE_MASK = 8'h7c;
	localparam logic [7:0] BAUD_RST  = 8'h00;
	localparam logic [7:0] BAUD_MASK = 8'h7f;

	// ==========================================================
	// Field positions of the flag and power registers
	localparam int FLAG_TXDONE = 0;
	localparam int PWR_HALT    = 0;
	localparam int PWR_STOP    = 1;

	// ==========================================================
	// Parity selections
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD  = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;

	// ==========================================================
	// Timing and bus constants
	localparam logic [4:0] CNT_HALF_M1 = 5'h0f;
	localparam logic [8:0] PSC_ONE     = 9'h001;
	localparam logic [8:0] PSC_BASE    = 9'h002;
	localparam logic [2:0] LAST_BIT7   = 3'h6;
	localparam logic [2:0] LAST_BIT8   = 3'h7;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Register layouts and receiver state type
	typedef struct packed {
		logic       resv7;
		logic       rx_enable_bit;
		logic [1:0] parity;
		logic       char8;
		logic       stop_length_bit;
		logic [1:0] resv;
	} asr_mode_t;

	typedef struct packed {
		logic       resv7;
		logic [2:0] prescale;
		logic [3:0] divisor;
	} asr_baud_t;

	typedef struct packed {
		logic [4:0] resv;
		logic       parity_err;
		logic       framing_err;
		logic       overrun_err;
	} asr_stat_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_PAR,
		ST_STOP
	} asr_state_t;

endpackage

// [rtl/asr_top.sv]
// Asynchronous serial receiver with AXI4-Lite register access.
module asr_top (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// AXI4-Lite write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Serial lines
	input  wire logic        rxd,
	input  wire logic        tx_bit_in,
	output logic             txd,
	// Events
	input  wire logic        tx_done_irq,
	output logic             rx_done_irq,
	output logic             rx_error_irq
);

	// ==========================================================
	// Declarations
	asr_pkg::asr_mode_t  mode_r;
	asr_pkg::asr_baud_t  baud_r;
	asr_pkg::asr_stat_t  stat_r;
	asr_pkg::asr_stat_t  stat_nxt;
	asr_pkg::asr_state_t st_r;
	logic [7:0]          rx_buf_r;
	logic [7:0]          rx_shift_r;
	logic [7:0]          psc_r;
	logic [7:0]          psc_max;
	logic [7:0]          frame_data;
	logic [4:0]          cnt5_r;
	logic [2:0]          bit_r;
	logic [2:0]          last_bit;
	logic                buf_full_r;
	logic                tx_flag_r;
	logic                halt_r;
	logic                stop_r;
	logic                ph_r;
	logic                par_r;
	logic                rxd_q_r;
	logic                cmpl_q_r;
	logic                run;
	logic                fsck;
	logic                hb;
	logic                smp;
	logic                cmpl;
	logic                rd_buf;
	logic                wr_en;
	logic                aw_got_r;
	logic                w_got_r;
	logic [7:0]          waddr_r;
	logic [7:0]          wbyte_r;
	logic                wlane_r;
	logic [31:0]         rd_word;
	logic                rd_hit;
	logic                wr_hit;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == asr_pkg::OFS_MODE) || (a == asr_pkg::OFS_BAUD) ||
			(a == asr_pkg::OFS_RXBUF) || (a == asr_pkg::OFS_STAT) ||
			(a == asr_pkg::OFS_FLAG) || (a == asr_pkg::OFS_PWR);
	endfunction

	// ==========================================================
	// Baud timing
	// Halt only idles the CPU, so it does not gate anything here.
	assign run = ~stop_r;
	assign psc_max = 8'((asr_pkg::PSC_BASE << baud_r.prescale) -
		asr_pkg::PSC_ONE);
	assign fsck = (psc_r == psc_max);
	assign hb = fsck &&
		(cnt5_r == ({1'b0, baud_r.divisor} + asr_pkg::CNT_HALF_M1));
	assign smp = hb && ph_r;
	assign last_bit = mode_r.char8 ? asr_pkg::LAST_BIT8 : asr_pkg::LAST_BIT7;
	assign cmpl = run && mode_r.rx_enable_bit &&
		(st_r == asr_pkg::ST_STOP) && smp;
	assign frame_data = mode_r.char8 ? rx_shift_r :
		{1'b0, rx_shift_r[7:1]};

	always_ff @(posedge mclk) begin
		if (sys_rst || st_r == asr_pkg::ST_IDLE) begin
			psc_r  <= 8'h00;
			cnt5_r <= 5'h00;
		end else if (run) begin
			psc_r <= fsck ? 8'h00 : psc_r + 8'h01;
			if (fsck) begin
				cnt5_r <= hb ? 5'h00 : cnt5_r + 5'h01;
			end
		end
	end

	// ==========================================================
	// Receive sequencer
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_r       <= asr_pkg::ST_IDLE;
			bit_r      <= 3'h0;
			rx_shift_r <= 8'h00;
			par_r      <= 1'b0;
			ph_r       <= 1'b0;
			rxd_q_r    <= 1'b1;
		end else if (!mode_r.rx_enable_bit) begin
			st_r    <= asr_pkg::ST_IDLE;
			ph_r    <= 1'b0;
			rxd_q_r <= rxd;
		end else if (run) begin
			rxd_q_r <= rxd;
			if (hb) begin
				ph_r <= ~ph_r;
			end
			case (st_r)
				asr_pkg::ST_IDLE: begin
					ph_r <= 1'b0;
					if (rxd_q_r && !rxd) begin
						st_r <= asr_pkg::ST_START;
					end
				end
				asr_pkg::ST_START: begin
					if (hb && !rxd) begin
						st_r  <= asr_pkg::ST_DATA;
						ph_r  <= 1'b0;
						bit_r <= 3'h0;
						par_r <= 1'b0;
					end else if (hb) begin
						st_r <= asr_pkg::ST_IDLE;
					end
				end
				asr_pkg::ST_DATA: begin
					if (smp) begin
						rx_shift_r <= {rxd, rx_shift_r[7:1]};
						par_r      <= par_r ^ rxd;
						bit_r      <= bit_r + 3'h1;
						if (bit_r == last_bit) begin
							st_r <= (mode_r.parity == asr_pkg::PAR_NONE) ?
								asr_pkg::ST_STOP : asr_pkg::ST_PAR;
						end
					end
				end
				asr_pkg::ST_PAR: begin
					if (smp) begin
						par_r <= par_r ^ rxd;
						st_r  <= asr_pkg::ST_STOP;
					end
				end
				asr_pkg::ST_STOP: begin
					if (smp) begin
						st_r <= asr_pkg::ST_IDLE;
					end
				end
				default: begin
					st_r <= asr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Buffer, error status and events
	always_comb begin
		stat_nxt = '0;
		stat_nxt.parity_err = mode_r.parity[1] &
			(par_r ^ ~mode_r.parity[0]);
		stat_nxt.framing_err = ~rxd;
		stat_nxt.overrun_err = buf_full_r;
	end

	// A frame landing in the same cycle as a buffer read wins over the clear.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_buf_r   <= 8'h00;
			stat_r     <= '0;
			buf_full_r <= 1'b0;
		end else if (cmpl) begin
			rx_buf_r   <= frame_data;
			stat_r     <= stat_nxt;
			buf_full_r <= 1'b1;
		end else if (rd_buf) begin
			stat_r     <= '0;
			buf_full_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_error_irq <= 1'b0;
			cmpl_q_r     <= 1'b0;
			rx_done_irq  <= 1'b0;
		end else begin
			rx_error_irq <= cmpl && (stat_nxt != '0);
			cmpl_q_r     <= cmpl;
			rx_done_irq  <= cmpl_q_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tx_flag_r <= 1'b0;
			txd       <= 1'b1;
		end else begin
			tx_flag_r <= tx_done_irq | (tx_flag_r & ~(wr_en && wlane_r &&
				waddr_r == asr_pkg::OFS_FLAG &&
				wbyte_r[asr_pkg::FLAG_TXDONE]));
			txd <= stop_r ? txd : tx_bit_in;
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	assign wr_en = aw_got_r && w_got_r && !bvalid;
	assign wr_hit = is_mapped(waddr_r);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			awready  <= 1'b0;
			wready   <= 1'b0;
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			waddr_r  <= 8'h00;
			wbyte_r  <= 8'h00;
			wlane_r  <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= asr_pkg::RESP_OKAY;
		end else begin
			awready <= awvalid && !awready && !aw_got_r && !bvalid;
			wready  <= wvalid && !wready && !w_got_r && !bvalid;
			if (awvalid && awready) begin
				aw_got_r <= 1'b1;
				waddr_r  <= awaddr;
			end
			if (wvalid && wready) begin
				w_got_r <= 1'b1;
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
			if (wr_en) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= wr_hit ? asr_pkg::RESP_OKAY :
					asr_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mode_r <= asr_pkg::MODE_RST;
			baud_r <= asr_pkg::BAUD_RST;
			halt_r <= 1'b0;
			stop_r <= 1'b0;
		end else if (wr_en && wlane_r) begin
			if (waddr_r == asr_pkg::OFS_MODE) begin
				mode_r <= wbyte_r & asr_pkg::MODE_MASK;
			end
			if (waddr_r == asr_pkg::OFS_BAUD) begin
				baud_r <= wbyte_r & asr_pkg::BAUD_MASK;
			end
			if (waddr_r == asr_pkg::OFS_PWR) begin
				halt_r <= wbyte_r[asr_pkg::PWR_HALT];
				stop_r <= wbyte_r[asr_pkg::PWR_STOP];
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	assign rd_buf = arvalid && arready && (araddr == asr_pkg::OFS_RXBUF);
	assign rd_hit = is_mapped(araddr);

	always_comb begin
		rd_word = 32'h0000_0000;
		case (araddr)
			asr_pkg::OFS_MODE:  rd_word[7:0] = mode_r;
			asr_pkg::OFS_BAUD:  rd_word[7:0] = baud_r;
			asr_pkg::OFS_RXBUF: rd_word[7:0] = rx_buf_r;
			asr_pkg::OFS_STAT:  rd_word[7:0] = stat_r;
			asr_pkg::OFS_FLAG:  rd_word[asr_pkg::FLAG_TXDONE] = tx_flag_r;
			asr_pkg::OFS_PWR: begin
				rd_word[asr_pkg::PWR_HALT] = halt_r;
				rd_word[asr_pkg::PWR_STOP] = stop_r;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= asr_pkg::RESP_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= rd_word;
				rresp  <= rd_hit ? asr_pkg::RESP_OKAY :
					asr_pkg::RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_start_ok;
		run && mode_r.rx_enable_bit && st_r == asr_pkg::ST_START &&
			hb && !rxd;
	endsequence
	sequence s_err_then_done;
		rx_error_irq ##1 rx_done_irq;
	endsequence
	property p_rx_off;
		!mode_r.rx_enable_bit |=> st_r == asr_pkg::ST_IDLE &&
			!rx_error_irq ##1 !rx_done_irq;
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("receiver not idle while disabled");
	property p_start_accept;
		s_start_ok |=> st_r == asr_pkg::ST_DATA && !ph_r && bit_r == 3'h0;
	endproperty
	a_start_accept: assert property (p_start_accept)
		else $error("start bit not accepted");
	property p_err_first;
		rx_error_irq |-> s_err_then_done;
	endproperty
	a_err_first: assert property (p_err_first)
		else $error("error event not followed by done event");
	property p_err_status;
		rx_error_irq |-> stat_r != '0;
	endproperty
	a_err_status: assert property (p_err_status)
		else $error("error event with clean status");
	property p_buf_copy;
		cmpl |=> rx_buf_r == $past(frame_data) ##1 rx_done_irq;
	endproperty
	a_buf_copy: assert property (p_buf_copy)
		else $error("frame not buffered or done event missing");
	property p_overrun;
		cmpl && buf_full_r |=> stat_r.overrun_err;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");
	property p_read_clear;
		rd_buf && !cmpl |=> stat_r == '0 && !buf_full_r;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status not cleared by buffer read");
	property p_framing;
		cmpl |=> stat_r.framing_err == !$past(rxd);
	endproperty
	a_framing: assert property (p_framing)
		else $error("framing flag wrong");
	property p_no_parity_err;
		cmpl && !mode_r.parity[1] |=> !stat_r.parity_err;
	endproperty
	a_no_parity_err: assert property (p_no_parity_err)
		else $error("parity error without checked parity");
	property p_seven_bit;
		cmpl && !mode_r.char8 |=> !rx_buf_r[7];
	endproperty
	a_seven_bit: assert property (p_seven_bit)
		else $error("bit 7 set in seven bit mode");
	property p_stop_freeze;
		stop_r && mode_r.rx_enable_bit |=> $stable(st_r) &&
			$stable(rx_shift_r) && $stable(rx_buf_r) && $stable(txd);
	endproperty
	a_stop_freeze: assert property (p_stop_freeze)
		else $error("activity during stop mode");

endmodule

// [verif/asr_tx_model.sv]
// Behavioural remote transmitter that drives the serial receive line.
module asr_tx_model (
	// Clock
	input  wire logic mclk,
	// Serial line
	output logic      rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Line idles high, as a pulled-up asynchronous line does.
	initial rxd = 1'b1;

	// ==========================================================
	// One frame: start, nb data bits, optional parity, one stop bit.
	task automatic send(input logic [7:0] d, input int nb, input bit pen,
		input logic pb, input logic st, input int bc);
		logic q[$];
		q = {1'b0};
		for (int i = 0; i < nb; i++) q.push_back(d[i]);
		if (pen) q.push_back(pb);
		q.push_back(st);
		foreach (q[i]) repeat (bc) @(posedge mclk) rxd <= q[i];
		@(posedge mclk) rxd <= 1'b1;
	endtask

	// ==========================================================
	// A low pulse too short to reach the start strobe.
	task automatic glitch(input int n);
		repeat (n) @(posedge mclk) rxd <= 1'b0;
		@(posedge mclk) rxd <= 1'b1;
	endtask
endmodule

// [verif/asr_top_tb_top.sv]
// Self-checking testbench of the serial receiver.
module asr_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals
	logic             mclk;
	logic             sys_rst;
	logic [7:0]       awaddr;
	logic [7:0]       araddr;
	logic             awvalid;
	logic             wvalid;
	logic             bready;
	logic             arvalid;
	logic             rready;
	logic [31:0]      wdata;
	logic [3:0]       wstrb;
	logic             tx_bit_in;
	logic             tx_done_irq;
	wire logic        awready;
	wire logic        wready;
	wire logic        bvalid;
	wire logic        arready;
	wire logic        rvalid;
	wire logic        rxd;
	wire logic        txd;
	wire logic        rx_done_irq;
	wire logic        rx_error_irq;
	wire logic [1:0]  bresp;
	wire logic [1:0]  rresp;
	wire logic [31:0] rdata;
	logic [31:0]      rd_v;
	logic [1:0]       rsp;
	int               n_mismatch;
	int               n_compared;
	int               cyc;
	int               n_done;
	int               n_err;
	int               t_done;
	int               t_err;

	asr_top asr_top_i (.mclk(mclk), .sys_rst(sys_rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rxd(rxd), .tx_bit_in(tx_bit_in), .txd(txd),
		.tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq),
		.rx_error_irq(rx_error_irq));
	asr_tx_model asr_tx_model_i (.mclk(mclk), .rxd(rxd));

	// ==========================================================
	// Clock and event monitor
	always #4 mclk = ~mclk;

	always @(posedge mclk) begin
		cyc++;
		if (rx_done_irq === 1'b1) begin
			n_done++;
			t_done = cyc;
		end
		if (rx_error_irq === 1'b1) begin
			n_err++;
			t_err = cyc;
		end
		if (cyc > 60000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask

	// Address and data are offered together and each dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd_v = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	// Sends one frame and judges status, buffer and both events.
	task automatic rx_case(input logic [7:0] md, input logic [7:0] d,
		input int nb, input bit pen, input logic pb, input logic st,
		input int bc, input logic [7:0] eb, input logic [7:0] es);
		wr(asr_pkg::OFS_MODE, md);
		rd(asr_pkg::OFS_RXBUF);
		n_done = 0;
		n_err = 0;
		asr_tx_model_i.send(d, nb, pen, pb, st, bc);
		chk("done events", 1, n_done);
		chk("error events", (es != 8'h00), n_err);
		if (es != 8'h00) chk("error lead", 1, t_done - t_err);
		rd(asr_pkg::OFS_STAT);
		chk("status", {24'h0, es}, rd_v);
		rd(asr_pkg::OFS_RXBUF);
		chk("buffer", {24'h0, eb}, rd_v);
		rd(asr_pkg::OFS_STAT);
		chk("status after read", 0, rd_v);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		chk("txd idle", 1, txd);
		rd(asr_pkg::OFS_MODE);
		chk("mode reset", {24'h0, asr_pkg::MODE_RST}, rd_v);
		wr(asr_pkg::OFS_MODE, 8'hff);
		rd(asr_pkg::OFS_MODE);
		chk("mode mask", {24'h0, asr_pkg::MODE_MASK}, rd_v);
		wr(asr_pkg::OFS_BAUD, 8'hff);
		rd(asr_pkg::OFS_BAUD);
		chk("baud mask", {24'h0, asr_pkg::BAUD_MASK}, rd_v);
		wr(asr_pkg::OFS_BAUD, 8'h00);
		rd(8'h20);
		chk("unmapped rresp", asr_pkg::RESP_SLVERR, rsp);
		chk("unmapped rdata", 0, rd_v);
		wr(8'h20, 8'h55);
		chk("unmapped bresp", asr_pkg::RESP_SLVERR, rsp);
	endtask

	task automatic t_codes();
		rx_case(8'h78, 8'ha5, 8, 1, 1'b0, 1'b1, 64, 8'ha5, 8'h00);
		rx_case(8'h78, 8'ha5, 8, 1, 1'b1, 1'b1, 64, 8'ha5, 8'h04);
		rx_case(8'h68, 8'h3c, 8, 1, 1'b1, 1'b1, 64, 8'h3c, 8'h00);
		rx_case(8'h68, 8'h3c, 8, 1, 1'b0, 1'b1, 64, 8'h3c, 8'h04);
		rx_case(8'h58, 8'h81, 8, 1, 1'b1, 1'b1, 64, 8'h81, 8'h00);
		rx_case(8'h48, 8'h96, 8, 0, 1'b0, 1'b1, 64, 8'h96, 8'h00);
		rx_case(8'h40, 8'hff, 7, 0, 1'b0, 1'b1, 64, 8'h7f, 8'h00);
		rx_case(8'h7c, 8'h12, 8, 1, 1'b0, 1'b1, 64, 8'h12, 8'h00);
		rx_case(8'h78, 8'h6e, 8, 1, 1'b1, 1'b0, 64, 8'h6e, 8'h02);
	endtask

	// Both clock fields change the bit period: 2^(p+2)*(k+16) cycles.
	task automatic t_baud();
		wr(asr_pkg::OFS_BAUD, 8'h11);
		rx_case(8'h48, 8'hc3, 8, 0, 1'b0, 1'b1, 136, 8'hc3, 8'h00);
		wr(asr_pkg::OFS_BAUD, 8'h00);
		n_done = 0;
		asr_tx_model_i.glitch(20);
		repeat (200) @(posedge mclk);
		chk("glitch events", 0, n_done);
	endtask

	task automatic t_overrun();
		wr(asr_pkg::OFS_MODE, 8'h48);
		rd(asr_pkg::OFS_RXBUF);
		asr_tx_model_i.send(8'h11, 8, 0, 1'b0, 1'b1, 64);
		asr_tx_model_i.send(8'h22, 8, 0, 1'b0, 1'b1, 64);
		rd(asr_pkg::OFS_STAT);
		chk("overrun status", 1, rd_v);
		n_err = 0;
		asr_tx_model_i.send(8'h33, 8, 0, 1'b0, 1'b1, 64);
		chk("overrun event", 1, n_err);
		rd(asr_pkg::OFS_STAT);
		chk("overrun kept", 1, rd_v);
		rd(asr_pkg::OFS_RXBUF);
		chk("latest frame", 8'h33, rd_v);
		rd(asr_pkg::OFS_STAT);
		chk("status cleared", 0, rd_v);
	endtask

	task automatic t_abort();
		wr(asr_pkg::OFS_MODE, 8'h78);
		rd(asr_pkg::OFS_RXBUF);
		asr_tx_model_i.send(8'h0f, 8, 1, 1'b1, 1'b1, 64);
		n_done = 0;
		n_err = 0;
		fork
			asr_tx_model_i.send(8'h33, 8, 1, 1'b1, 1'b1, 64);
			begin
				repeat (300) @(posedge mclk);
				wr(asr_pkg::OFS_MODE, 8'h38);
			end
		join
		asr_tx_model_i.send(8'h44, 8, 1, 1'b1, 1'b1, 64);
		chk("aborted events", 0, n_done + n_err);
		rd(asr_pkg::OFS_STAT);
		chk("status kept", 4, rd_v);
		rd(asr_pkg::OFS_RXBUF);
		chk("buffer kept", 8'h0f, rd_v);
	endtask

	task automatic t_power();
		wr(asr_pkg::OFS_PWR, 8'h01);
		rx_case(8'h48, 8'h5a, 8, 0, 1'b0, 1'b1, 64, 8'h5a, 8'h00);
		tx_bit_in <= 1'b0;
		wr(asr_pkg::OFS_PWR, 8'h02);
		tx_bit_in <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("txd frozen", 0, txd);
		rd(asr_pkg::OFS_MODE);
		chk("mode frozen", 8'h48, rd_v);
		wr(asr_pkg::OFS_PWR, 8'h00);
		repeat (3) @(posedge mclk);
		chk("txd free", 1, txd);
		@(posedge mclk) tx_done_irq <= 1'b1;
		@(posedge mclk) tx_done_irq <= 1'b0;
		rd(asr_pkg::OFS_FLAG);
		chk("tx flag set", 1, rd_v);
		wr(asr_pkg::OFS_FLAG, 8'h01);
		rd(asr_pkg::OFS_FLAG);
		chk("tx flag clear", 0, rd_v);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		wdata = 32'h00000000;
		wstrb = 4'hf;
		tx_bit_in = 1'b1;
		tx_done_irq = 1'b0;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		t_regs();
		t_codes();
		t_baud();
		t_overrun();
		t_abort();
		t_power();
		give_verdict();
	end
endmodule
